// ---- logic/ced_regs.svh ----
// Named constants for the configuration entry decoder: tuple codes, field
// positions and limits.
// Assumes it is included once per compilation unit by its bare name.
`ifndef CED_REGS_SVH
`define CED_REGS_SVH

// Tuple codes seen in the structure, and the configuration link minimum.
`define CED_CODE_NULL 8'h00
`define CED_CODE_ENTRY 8'h05
`define CED_CODE_CONFIG 8'h1A
`define CED_CODE_END 8'hFF
`define CED_SUB_END 8'hFF
`define CED_CFG_LINK_MIN 8'h05

// Feature select byte fields.
`define CED_FS_POWER 1:0
`define CED_FS_RSV_A 2
`define CED_FS_IO 3
`define CED_FS_IRQ 4
`define CED_FS_MEM 5
`define CED_FS_RSV_B 6
`define CED_FS_MISC 7

// Register map bytes.
`define CED_IO_MAP 5:1
`define CED_IO_RSV_LO 0
`define CED_IO_RSV_HI 7:6
`define CED_MEM_MAP 7:1
`define CED_MEM_RSV 0

// Interrupt descriptor fields and the extra mask bytes that follow it.
`define CED_IRQ_MASK 4
`define CED_IRQ_LEVEL 5
`define CED_IRQ_PULSE 6
`define CED_IRQ_MASK_BYTES 2'h2

// Miscellaneous feature bytes.
`define CED_EXT 7
`define CED_MISC_CMD 5:0
`define CED_MISC_FB2B 6
`define CED_MISC_PWM 0
`define CED_MISC_BIN 1
`define CED_MISC_WAKE 2
`define CED_MISC_RSV 6:3
`define CED_MISC_VAL 6:0
`define CED_THERMAL_MAX 7'h63
`define CED_MISC_CMD_IDX 3'h0
`define CED_MISC_CAP_IDX 3'h1
`define CED_MISC_MAJ_IDX 3'h2
`define CED_MISC_MIN_IDX 3'h3
`define CED_MISC_LAST_IDX 3'h4

// Index byte field.
`define CED_INDEX_NUM 5:0

`endif

// ---- logic/ced_pkg.sv ----
// Types shared by the configuration entry decoder.
// Assumes the constants header is compiled alongside.
package ced_pkg;

    typedef enum logic [3:0] {
        CED_S_CODE = 4'h0,
        CED_S_LINK = 4'h1,
        CED_S_INDEX = 4'h2,
        CED_S_FSEL = 4'h3,
        CED_S_PWRSEL = 4'h4,
        CED_S_PWRVAL = 4'h5,
        CED_S_IO = 4'h6,
        CED_S_IRQ = 4'h7,
        CED_S_MEM = 4'h8,
        CED_S_MISC = 4'h9,
        CED_S_STCODE = 4'hA,
        CED_S_STLINK = 4'hB,
        CED_S_STBODY = 4'hC,
        CED_S_SKIP = 4'hD,
        CED_S_DONE = 4'hE
    } ced_state_t;

    typedef logic [7:0] ced_byte_t;

endpackage

// ---- logic/ced_decoder.sv ----
// Configuration entry decoder: walks the tuple chain one byte at a time and
// decodes the trailing fields of each configuration table entry.
// Assumes the host drives the byte stream from the same clock domain.
`timescale 1ns/10ps
`include "ced_regs.svh"

// Notes on behaviour
// [RULE_01] I/O map byte bits one to five mark I/O BARs; others reserved.
// [RULE_02] Every I/O space must also be reachable through a memory BAR.
// [RULE_03] I/O BARs sit directly before the single memory BAR mapping them.
// [RULE_04] With interrupts selected, level flag is one and pulse flag zero.
// [RULE_05] Memory map byte bits one to seven mark memory BARs; bit zero reserved.
// [RULE_06] A used expansion ROM BAR appears in the memory bitmap.
// [RULE_07] Misc bytes: extension flag set on all but last, cleared on last.
// [RULE_08] Trailing misc bytes may be dropped; last present byte ends chain.
// [RULE_09] Host copies first misc byte bits into its command register.
// [RULE_10] First misc byte bit six reports fast back-to-back, not a command.
// [RULE_11] Second misc byte: bits three to six reserved zero; capability flags below.
// [RULE_12] Audio flags say whether PWM and binary audio can be supplied.
// [RULE_13] Wakeup flag is read-only: one supports wakeup, zero does not.
// [RULE_14] Third misc byte holds integer thermal part; its bit seven is one.
// [RULE_15] Fourth misc byte holds thermal hundredths; bit seven extends further.
// [RULE_16] Each thermal part must be at most 63h; larger values are invalid.
// [RULE_17] Host keeps reading misc bytes until one has extension flag clear.
// [RULE_18] Subtuples in code-link-body form fill the entry after its fields.
// [RULE_19] With no configuration tuple the host assumes a memory-only card.
// [RULE_20] At most one configuration tuple; a second one is flagged.
// [RULE_21] Configuration tuple code is 1Ah and its link is at least five.
// [RULE_22] Host may configure, leave unconfigured, or reject the card.
// [RULE_23] Optional fields follow feature select bit order, bit zero first.
// [RULE_24] Absent misc field means every misc feature bit reads zero.
// [RULE_25] Nonzero reserved bits in maps or misc bytes flag a malformed entry.
// [RULE_26] One byte per clock under valid and ready; reset clears outputs.
module ced_decoder (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // Scan control
    input wire logic scanStart,
    output logic scanDone,
    output logic memoryOnly,
    output logic configDuplicate,
    output logic configLinkShort,
    // Descriptor byte stream
    input wire logic byteValid,
    input wire ced_pkg::ced_byte_t byteData,
    output logic byteReady,
    // Decoded entry
    output logic entryDone,
    output logic [5:0] entryIndex,
    output logic [4:0] ioBarMap,
    output logic [6:0] memBarMap,
    output logic irqPresent,
    output logic irqModeError,
    output logic barOrderError,
    output logic [5:0] commandHints,
    output logic fastBackToBack,
    output logic audioPwm,
    output logic audioBinary,
    output logic wakeupSupport,
    output logic [6:0] thermalMajor,
    output logic [6:0] thermalMinor,
    output logic thermalInvalid,
    output logic [2:0] miscByteCount,
    output logic [3:0] subtupleCount,
    output logic malformed
);
    import ced_pkg::*;

    typedef struct packed {
        ced_state_t st;
        logic [7:0] rem;
        logic isEntry;
        logic isConfig;
        logic [7:0] fsel;
        logic [1:0] pwrLeft;
        logic [2:0] valLeft;
        logic [1:0] irqSkip;
        logic [2:0] miscIdx;
        logic [7:0] stLeft;
        logic ready;
        logic scanDone;
        logic memoryOnly;
        logic cfgSeen;
        logic cfgDup;
        logic cfgLinkShort;
        logic entryDone;
        logic [5:0] entryIdx;
        logic [4:0] ioMap;
        logic [6:0] memMap;
        logic irqSeen;
        logic irqModeErr;
        logic barOrderErr;
        logic [5:0] cmdHints;
        logic fb2b;
        logic pwm;
        logic bin;
        logic wake;
        logic [6:0] thMaj;
        logic [6:0] thMin;
        logic thBad;
        logic [3:0] subCount;
        logic malformed;
    } ced_regs_t;

    ced_regs_t s;
    ced_regs_t next_s;

    // Picks the first present field at or after the given position.
    function automatic ced_state_t nextField(input logic [7:0] fs, input logic [2:0] from);
        ced_state_t r;
        r = CED_S_STCODE;
        if (from <= 3'h4 && fs[`CED_FS_MISC]) begin
            r = CED_S_MISC;
        end
        if (from <= 3'h3 && fs[`CED_FS_MEM]) begin
            r = CED_S_MEM;
        end
        if (from <= 3'h2 && fs[`CED_FS_IRQ]) begin
            r = CED_S_IRQ;
        end
        if (from <= 3'h1 && fs[`CED_FS_IO]) begin
            r = CED_S_IO;
        end
        if (from == 3'h0 && fs[`CED_FS_POWER] != 2'h0) begin
            r = CED_S_PWRSEL;
        end
        return r;
    endfunction

    // Counts the parameter values announced by a power select byte.
    function automatic logic [2:0] popCount(input logic [6:0] v);
        logic [2:0] c;
        c = 3'h0;
        for (int i = 0; i < 7; i++) begin
            c = c + {2'h0, v[i]};
        end
        return c;
    endfunction

    // Each I/O BAR must be followed by another I/O BAR or by the memory BAR
    // that maps the whole run, and no BAR may be both at once.
    function automatic logic barOrderOk(input logic [4:0] io, input logic [6:0] mem);
        logic [6:0] io7;
        logic ok;
        io7 = {2'h0, io};
        ok = 1'b1;
        for (int i = 0; i < 5; i++) begin
            if (io7[i] && (mem[i] || !(io7[i + 1] || mem[i + 1]))) begin
                ok = 1'b0;
            end
        end
        return ok;
    endfunction

    always_comb begin
        next_s = s;
        next_s.ready = 1'b1;
        next_s.entryDone = 1'b0;
        next_s.scanDone = 1'b0;
        if (scanStart) begin
            next_s.st = CED_S_CODE;
            next_s.cfgSeen = 1'b0;
            next_s.cfgDup = 1'b0;
            next_s.cfgLinkShort = 1'b0;
            next_s.memoryOnly = 1'b0;
        // [RULE_26] Byte handshake accept.
        end else if (byteValid && s.ready) begin
            if (s.st != CED_S_CODE && s.st != CED_S_LINK && s.st != CED_S_DONE) begin
                next_s.rem = s.rem - 8'h01;
            end
            unique case (s.st)
                CED_S_CODE: begin
                    if (byteData == `CED_CODE_END) begin
                        // [RULE_19] Memory-only report.
                        next_s.memoryOnly = !s.cfgSeen;
                        next_s.scanDone = 1'b1;
                        next_s.st = CED_S_DONE;
                    end else if (byteData != `CED_CODE_NULL) begin
                        next_s.isEntry = (byteData == `CED_CODE_ENTRY);
                        next_s.isConfig = (byteData == `CED_CODE_CONFIG);
                        // [RULE_20] Duplicate configuration tuple.
                        if (byteData == `CED_CODE_CONFIG) begin
                            next_s.cfgDup = s.cfgDup | s.cfgSeen;
                            next_s.cfgSeen = 1'b1;
                        end
                        next_s.st = CED_S_LINK;
                    end
                end
                CED_S_LINK: begin
                    next_s.rem = byteData;
                    // [RULE_21] Configuration link minimum.
                    if (s.isConfig && byteData < `CED_CFG_LINK_MIN) begin
                        next_s.cfgLinkShort = 1'b1;
                    end
                    if (byteData == 8'h00) begin
                        next_s.st = CED_S_CODE;
                    end else if (s.isEntry) begin
                        next_s.st = CED_S_INDEX;
                    end else begin
                        next_s.st = CED_S_SKIP;
                    end
                end
                CED_S_INDEX: begin
                    // [RULE_24] Absent fields read zero.
                    next_s.entryIdx = byteData[`CED_INDEX_NUM];
                    next_s.ioMap = 5'h0;
                    next_s.memMap = 7'h0;
                    next_s.irqSeen = 1'b0;
                    next_s.irqModeErr = 1'b0;
                    next_s.barOrderErr = 1'b0;
                    next_s.cmdHints = 6'h0;
                    next_s.fb2b = 1'b0;
                    next_s.pwm = 1'b0;
                    next_s.bin = 1'b0;
                    next_s.wake = 1'b0;
                    next_s.thMaj = 7'h0;
                    next_s.thMin = 7'h0;
                    next_s.thBad = 1'b0;
                    next_s.miscIdx = 3'h0;
                    next_s.irqSkip = 2'h0;
                    next_s.subCount = 4'h0;
                    next_s.malformed = 1'b0;
                    next_s.st = CED_S_FSEL;
                end
                CED_S_FSEL: begin
                    next_s.fsel = byteData;
                    next_s.pwrLeft = byteData[`CED_FS_POWER];
                    if (byteData[`CED_FS_RSV_A] || byteData[`CED_FS_RSV_B]) begin
                        next_s.malformed = 1'b1;
                    end
                    // [RULE_23] Field order walk.
                    next_s.st = nextField(byteData, 3'h0);
                end
                CED_S_PWRSEL: begin
                    next_s.valLeft = popCount(byteData[6:0]);
                    if (byteData[6:0] != 7'h0) begin
                        next_s.st = CED_S_PWRVAL;
                    end else begin
                        next_s.pwrLeft = s.pwrLeft - 2'h1;
                        next_s.st = (s.pwrLeft == 2'h1) ? nextField(s.fsel, 3'h1) : CED_S_PWRSEL;
                    end
                end
                CED_S_PWRVAL: begin
                    // Extension bytes of a value keep the count where it is.
                    if (!byteData[`CED_EXT]) begin
                        next_s.valLeft = s.valLeft - 3'h1;
                        if (s.valLeft == 3'h1) begin
                            next_s.pwrLeft = s.pwrLeft - 2'h1;
                            next_s.st = (s.pwrLeft == 2'h1) ? nextField(s.fsel, 3'h1) : CED_S_PWRSEL;
                        end
                    end
                end
                CED_S_IO: begin
                    // [RULE_01] I/O bitmap capture.
                    next_s.ioMap = byteData[`CED_IO_MAP];
                    // [RULE_25] Reserved map bits.
                    if (byteData[`CED_IO_RSV_LO] || byteData[`CED_IO_RSV_HI] != 2'h0) begin
                        next_s.malformed = 1'b1;
                    end
                    next_s.st = nextField(s.fsel, 3'h2);
                end
                CED_S_IRQ: begin
                    if (s.irqSkip != 2'h0) begin
                        next_s.irqSkip = s.irqSkip - 2'h1;
                        if (s.irqSkip == 2'h1) begin
                            next_s.st = nextField(s.fsel, 3'h3);
                        end
                    end else begin
                        next_s.irqSeen = 1'b1;
                        // [RULE_04] Level mode only.
                        next_s.irqModeErr = !byteData[`CED_IRQ_LEVEL] || byteData[`CED_IRQ_PULSE];
                        if (byteData[`CED_IRQ_MASK]) begin
                            next_s.irqSkip = `CED_IRQ_MASK_BYTES;
                        end else begin
                            next_s.st = nextField(s.fsel, 3'h3);
                        end
                    end
                end
                CED_S_MEM: begin
                    // [RULE_05] Memory bitmap capture.
                    // [RULE_06] ROM BAR included.
                    next_s.memMap = byteData[`CED_MEM_MAP];
                    if (byteData[`CED_MEM_RSV]) begin
                        next_s.malformed = 1'b1;
                    end
                    next_s.st = nextField(s.fsel, 3'h4);
                end
                CED_S_MISC: begin
                    unique case (s.miscIdx)
                        `CED_MISC_CMD_IDX: begin
                            // [RULE_09] Command hints out.
                            next_s.cmdHints = byteData[`CED_MISC_CMD];
                            // [RULE_10] Fast back-to-back status.
                            next_s.fb2b = byteData[`CED_MISC_FB2B];
                        end
                        `CED_MISC_CAP_IDX: begin
                            // [RULE_11] Reserved capability bits.
                            if (byteData[`CED_MISC_RSV] != 4'h0) begin
                                next_s.malformed = 1'b1;
                            end
                            // [RULE_12] Audio capability flags.
                            next_s.pwm = byteData[`CED_MISC_PWM];
                            next_s.bin = byteData[`CED_MISC_BIN];
                            // [RULE_13] Wakeup capability.
                            next_s.wake = byteData[`CED_MISC_WAKE];
                        end
                        `CED_MISC_MAJ_IDX: begin
                            // [RULE_14] Integer thermal part.
                            next_s.thMaj = byteData[`CED_MISC_VAL];
                            if (!byteData[`CED_EXT]) begin
                                next_s.malformed = 1'b1;
                            end
                            // [RULE_16] Thermal range check.
                            if (byteData[`CED_MISC_VAL] > `CED_THERMAL_MAX) begin
                                next_s.thBad = 1'b1;
                            end
                        end
                        `CED_MISC_MIN_IDX: begin
                            // [RULE_15] Hundredths thermal part.
                            next_s.thMin = byteData[`CED_MISC_VAL];
                            if (byteData[`CED_MISC_VAL] > `CED_THERMAL_MAX) begin
                                next_s.thBad = 1'b1;
                            end
                        end
                        default: begin
                            // Later bytes carry no defined features yet.
                        end
                    endcase
                    if (s.miscIdx != `CED_MISC_LAST_IDX) begin
                        next_s.miscIdx = s.miscIdx + 3'h1;
                    end
                    // [RULE_07] Extension chain end.
                    // [RULE_08] Shortened chain accepted.
                    if (!byteData[`CED_EXT]) begin
                        next_s.st = CED_S_STCODE;
                    end
                end
                CED_S_STCODE: begin
                    // [RULE_18] Subtuple walk.
                    next_s.subCount = s.subCount + 4'h1;
                    next_s.st = (byteData == `CED_SUB_END) ? CED_S_SKIP : CED_S_STLINK;
                end
                CED_S_STLINK: begin
                    next_s.stLeft = byteData;
                    // A subtuple must not run past the end of its entry.
                    if (byteData > s.rem - 8'h01) begin
                        next_s.malformed = 1'b1;
                    end
                    next_s.st = (byteData == 8'h00) ? CED_S_STCODE : CED_S_STBODY;
                end
                CED_S_STBODY: begin
                    next_s.stLeft = s.stLeft - 8'h01;
                    if (s.stLeft == 8'h01) begin
                        next_s.st = CED_S_STCODE;
                    end
                end
                CED_S_SKIP: begin
                    // Body of a tuple this block does not decode.
                end
                CED_S_DONE: begin
                    // Chain ended; bytes are consumed and ignored.
                end
            endcase
            if (s.st != CED_S_CODE && s.st != CED_S_LINK && s.st != CED_S_DONE && s.rem == 8'h01) begin
                next_s.st = CED_S_CODE;
                if (s.isEntry) begin
                    next_s.entryDone = 1'b1;
                    // [RULE_02] I/O memory-mapped too.
                    // [RULE_03] BAR ordering check.
                    next_s.barOrderErr = !barOrderOk(next_s.ioMap, next_s.memMap);
                end
            end
        end
    end

    // [RULE_26] Synchronous clear.
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign byteReady = s.ready;
    assign scanDone = s.scanDone;
    assign memoryOnly = s.memoryOnly;
    assign configDuplicate = s.cfgDup;
    assign configLinkShort = s.cfgLinkShort;
    assign entryDone = s.entryDone;
    assign entryIndex = s.entryIdx;
    assign ioBarMap = s.ioMap;
    assign memBarMap = s.memMap;
    assign irqPresent = s.irqSeen;
    assign irqModeError = s.irqModeErr;
    assign barOrderError = s.barOrderErr;
    assign commandHints = s.cmdHints;
    assign fastBackToBack = s.fb2b;
    assign audioPwm = s.pwm;
    assign audioBinary = s.bin;
    assign wakeupSupport = s.wake;
    assign thermalMajor = s.thMaj;
    assign thermalMinor = s.thMin;
    assign thermalInvalid = s.thBad;
    assign miscByteCount = s.miscIdx;
    assign subtupleCount = s.subCount;
    assign malformed = s.malformed;

endmodule

// ---- test/ced_decoder_properties.sv ----
// Concurrent checks on the configuration entry decoder ports.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/10ps
module ced_decoder_properties (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // Stream inputs
    input wire logic scanStart,
    input wire logic byteValid,
    input wire ced_pkg::ced_byte_t byteData,
    // Watched outputs
    input wire logic byteReady,
    input wire logic scanDone,
    input wire logic memoryOnly,
    input wire logic configDuplicate,
    input wire logic configLinkShort,
    input wire logic entryDone,
    input wire logic [6:0] thermalMajor,
    input wire logic [6:0] thermalMinor,
    input wire logic thermalInvalid,
    input wire logic [2:0] miscByteCount,
    input wire logic [4:0] ioBarMap,
    input wire logic [6:0] memBarMap,
    input wire logic malformed
);
    import ced_pkg::*;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    a_ready_after_reset:
        assert property ($fell(reset) |-> ##[1:2] byteReady) else $error("byteReady late after reset");
    a_reset_clears_fields:
        assert property ($past(reset) |-> (ioBarMap == 5'h00 && memBarMap == 7'h00 && !malformed))
        else $error("fields not cleared by reset");
    a_entry_done_pulse:
        assert property (entryDone |=> !entryDone) else $error("entryDone longer than one cycle");
    a_done_after_byte:
        assert property (entryDone |-> $past(byteValid && byteReady)) else $error("entryDone without a taken byte");
    a_scan_done_pulse:
        assert property (scanDone |=> !scanDone) else $error("scanDone longer than one cycle");
    a_start_clears_flags:
        assert property (scanStart |=> !(configDuplicate || configLinkShort || memoryOnly))
        else $error("scan flags not cleared by scanStart");
    a_dup_from_code:
        assert property ($rose(configDuplicate) |-> $past(byteValid) && $past(byteData) == 8'h1A)
        else $error("duplicate flag without a config code");
    a_short_from_link:
        assert property ($rose(configLinkShort) |-> $past(byteValid) && $past(byteData) < 8'h05)
        else $error("short link flag without a short link");
    a_memonly_at_done:
        assert property ($rose(memoryOnly) |-> scanDone) else $error("memoryOnly outside scanDone");
    a_thermal_range:
        assert property ((thermalMajor > 7'h63 || thermalMinor > 7'h63) |-> thermalInvalid)
        else $error("thermal part above range not flagged");
    a_misc_count_cap:
        assert property (miscByteCount <= 3'h4) else $error("misc byte count above four");

    c_entry: cover property (entryDone);
    c_mem_only: cover property (scanDone && memoryOnly);
    c_dup: cover property ($rose(configDuplicate));
endmodule

// ---- test/ced_host_model.sv ----
// Host side model: scans descriptor bytes into the decoder one per clock.
// Assumes it is called just after a rising edge of clk_sys.
`timescale 1ns/10ps
module ced_host_model (
    // Clock
    input wire logic clk_sys,
    // Byte stream
    input wire logic byteReady,
    output ced_pkg::ced_byte_t byteData,
    output logic byteValid,
    // Status
    output logic hungUp
);
    import ced_pkg::*;
    initial begin
        byteValid = 1'b0;
        byteData = 8'h00;
        hungUp = 1'b0;
    end

    // Whole tuples in order.
    // A released data line shows the inverse of the last byte so stale data never looks valid.
    task automatic send_bytes(input ced_byte_t list[$]);
        int waitN;
        foreach (list[i]) begin
            byteValid <= 1'b1;
            byteData <= list[i];
            waitN = 0;
            do begin
                @(posedge clk_sys);
                waitN++;
            end while (!byteReady && waitN < 50);
            if (!byteReady) begin
                hungUp <= 1'b1;
            end
        end
        byteValid <= 1'b0;
        byteData <= ~list[list.size() - 1];
    endtask
endmodule

// ---- test/tb_top.sv ----
// Self-checking bench for the configuration entry decoder.
// Assumes the host model drives the stream and the checker is bound below.
`timescale 1ns/10ps
module tb_top;
    import ced_pkg::*;
    logic clk_sys, reset, scanStart, byteValid, byteReady, hungUp;
    ced_byte_t byteData;
    logic scanDone, memoryOnly, configDuplicate, configLinkShort, entryDone, irqPresent, irqModeError;
    logic barOrderError, fastBackToBack, audioPwm, audioBinary, wakeupSupport, thermalInvalid, malformed;
    logic [5:0] entryIndex, commandHints;
    logic [4:0] ioBarMap;
    logic [6:0] memBarMap, thermalMajor, thermalMinor;
    logic [2:0] miscByteCount;
    logic [3:0] subtupleCount;
    int n_mismatch = 0;
    int n_checks = 0;

    ced_decoder DUT (.clk_sys, .reset, .scanStart, .scanDone, .memoryOnly, .configDuplicate,
        .configLinkShort, .byteValid, .byteData, .byteReady, .entryDone, .entryIndex, .ioBarMap,
        .memBarMap, .irqPresent, .irqModeError, .barOrderError, .commandHints, .fastBackToBack,
        .audioPwm, .audioBinary, .wakeupSupport, .thermalMajor, .thermalMinor, .thermalInvalid,
        .miscByteCount, .subtupleCount, .malformed);
    ced_host_model host (.clk_sys, .byteReady, .byteData, .byteValid, .hungUp);

    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic close_out();
        $display("Checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic start_scan();
        scanStart <= 1'b1;
        @(posedge clk_sys);
        scanStart <= 1'b0;
    endtask

    // The end pulse stands for one cycle only, so it is read at the very next edge.
    task automatic finish_scan(input logic expMemOnly);
        @(posedge clk_sys);
        chk("scanDone", 8'h01, 8'(scanDone));
        chk("memoryOnly", 8'(expMemOnly), 8'(memoryOnly));
        chk("hungUp", 8'h00, 8'(hungUp));
        if (hungUp) begin
            close_out();
        end
        repeat (2) @(posedge clk_sys);
    endtask

    initial begin
        reset = 1'b1;
        scanStart = 1'b0;
        repeat (20) @(posedge clk_sys);
        reset <= 1'b0;
        repeat (3) @(posedge clk_sys);
        start_scan();
        host.send_bytes('{8'h1A, 8'h05, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h05, 8'h0A, 8'h03, 8'hB8,
            8'h06, 8'h20, 8'h08, 8'hC5, 8'h86, 8'h99, 8'h4B, 8'hFF, 8'hFF});
        finish_scan(1'b0);
        chk("entryIndex", 8'h03, 8'(entryIndex));
        chk("ioBarMap", 8'h03, 8'(ioBarMap));
        chk("memBarMap", 8'h04, 8'(memBarMap));
        chk("errors", 8'h00, 8'({irqModeError, barOrderError, malformed, thermalInvalid, configDuplicate,
            configLinkShort}));
        chk("commandHints", 8'h05, 8'(commandHints));
        chk("caps", 8'h1E, 8'({irqPresent, fastBackToBack, wakeupSupport, audioBinary, audioPwm}));
        chk("thermalMajor", 8'h19, 8'(thermalMajor));
        chk("thermalMinor", 8'h4B, 8'(thermalMinor));
        chk("counts", 8'h41, 8'({miscByteCount, subtupleCount}));
        start_scan();
        host.send_bytes('{8'h05, 8'h02, 8'h07, 8'h00, 8'hFF});
        finish_scan(1'b1);
        chk("absentMisc", 8'h00, 8'({commandHints, fastBackToBack, wakeupSupport}));
        start_scan();
        host.send_bytes('{8'h1A, 8'h04, 8'h00, 8'h00, 8'h00, 8'h00, 8'h1A, 8'h05, 8'h00, 8'h00, 8'h00,
            8'h00, 8'h00, 8'h05, 8'h06, 8'h01, 8'hB0, 8'h40, 8'h01, 8'h80, 8'h78, 8'hFF});
        finish_scan(1'b0);
        chk("errors", 8'h2B, 8'({irqModeError, barOrderError, malformed, thermalInvalid, configDuplicate,
            configLinkShort}));
        chk("memBarMap", 8'h00, 8'(memBarMap));
        chk("caps", 8'h10, 8'({irqPresent, fastBackToBack, wakeupSupport, audioBinary, audioPwm}));
        chk("counts", 8'h20, 8'({miscByteCount, subtupleCount}));
        start_scan();
        host.send_bytes('{8'h05, 8'h07, 8'h02, 8'h88, 8'h02, 8'h80, 8'h80, 8'hE4, 8'h10, 8'hFF});
        finish_scan(1'b1);
        chk("errors", 8'h14, 8'({irqModeError, barOrderError, malformed, thermalInvalid, configDuplicate,
            configLinkShort}));
        chk("thermalMajor", 8'h64, 8'(thermalMajor));
        chk("ioBarMap", 8'h01, 8'(ioBarMap));
        chk("counts", 8'h40, 8'({miscByteCount, subtupleCount}));
        reset <= 1'b1;
        repeat (2) @(posedge clk_sys);
        reset <= 1'b0;
        @(posedge clk_sys);
        chk("afterReset", 8'h00, {thermalMajor, byteReady});
        close_out();
    end
endmodule

bind ced_decoder ced_decoder_properties u_props (.clk_sys, .reset, .scanStart, .byteValid, .byteData,
    .byteReady, .scanDone, .memoryOnly, .configDuplicate, .configLinkShort, .entryDone, .thermalMajor,
    .thermalMinor, .thermalInvalid, .miscByteCount, .ioBarMap, .memBarMap, .malformed);
